/* File: logic/acst_pkg.sv */
package acst_pkg;

    // register offsets
    localparam logic [7:0] OFS_VENDOR_CODE        = 8'h00;
    localparam logic [7:0] OFS_FAMILY_CODE        = 8'h01;
    localparam logic [7:0] OFS_PART_CODE          = 8'h02;
    localparam logic [7:0] OFS_SILICON_REVISION   = 8'h03;
    localparam logic [7:0] OFS_X_ACCEL_UPPER_BYTE = 8'h08;
    localparam logic [7:0] OFS_Y_ACCEL_UPPER_BYTE = 8'h09;
    localparam logic [7:0] OFS_Z_ACCEL_UPPER_BYTE = 8'h0A;
    localparam logic [7:0] OFS_CONDITION_FLAGS    = 8'h0B;
    localparam logic [7:0] OFS_QUEUE_COUNT_LOW    = 8'h0C;
    localparam logic [7:0] OFS_QUEUE_COUNT_HIGH   = 8'h0D;
    localparam logic [7:0] OFS_X_ACCEL_LOW_BYTE   = 8'h0E;
    localparam logic [7:0] OFS_X_ACCEL_HIGH_BYTE  = 8'h0F;
    localparam logic [7:0] OFS_LAST_STANDBY_ONLY  = 8'h2C;

    // condition flag bit positions
    localparam int FLG_CONFIG_ERROR = 7;
    localparam int FLG_AWAKE        = 6;
    localparam int FLG_STILLNESS    = 5;
    localparam int FLG_MOTION       = 4;
    localparam int FLG_OVERRUN      = 3;
    localparam int FLG_WATERMARK    = 2;
    localparam int FLG_QUEUE_READY  = 1;
    localparam int FLG_DATA_READY   = 0;

    // reset values
    localparam logic [7:0]  RST_CONDITION_FLAGS = 8'h40;
    localparam logic [7:0]  RST_DATA_BYTE       = 8'h00;
    localparam logic [11:0] RST_SAMPLE          = 12'h000;

    // widths
    localparam int SAMPLE_W = 12;
    localparam int COUNT_W  = 10;

endpackage : acst_pkg

/* File: logic/acst_regs.sv */
// Operation
// [R1] host changes registers up to 0x2C only while sensor is in standby
// [R2] fixed read-only vendor, family and part codes at 0x00 to 0x02
// [R3] read-only silicon revision at 0x03, first value then plus one per revision
// [R4] 0x08 to 0x0A give upper eight bits of x, y, z results
// [R5] flag register at 0x0B is read-only and resets to 0x40; code resets it to 0xC0 because bit 7 is also set at reset [R6]
// [R6] bit 7 set at power-up and soft reset, cleared by any write command; code keeps it set when config_upset comes in the same cycle
// [R7] bit 7 also set when an upset corrupts stored configuration
// [R8] bit 6 shows awake state; held at 1 unless linked or loop mode; code has no loop mode and follows awake_state only when linked_mode
// [R9] bit 5 set when stillness or free-fall detected
// [R10] bit 4 set when over-threshold motion detected
// [R11] bit 3 set when queue overflows and replaces unread sample
// [R12] bit 2 set while queue count reaches programmed watermark
// [R13] bit 1 set while at least one sample waits in queue
// [R14] bit 0 set on new sample, cleared by queue read
// [R15] queue count reported from 0 to 512
// [R16] count low byte at 0x0C, two upper bits at 0x0D low positions
// [R17] 12-bit x result: low eight bits 0x0E, high four bits 0x0F
// [R18] bits 15 to 12 of x high register copy bit 11
// [R19] upper-byte registers equal bits 11 to 4 of the same sample
module acst_regs #(
    parameter logic [7:0] VENDOR_CODE    = 8'h5A, // arbitrary value
    parameter logic [7:0] FAMILY_CODE    = 8'h3C, // arbitrary value
    parameter logic [7:0] PART_CODE      = 8'h66, // arbitrary value
    parameter logic [7:0] SILICON_REV    = 8'h07  // arbitrary value
) (
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           resetn,
    input  wire logic                           soft_reset,
    // register read port
    input  wire logic                           rd_en,
    input  wire logic [7:0]                     rd_addr,
    output logic      [7:0]                     rd_data,
    output logic                                rd_valid,
    // host command events
    input  wire logic                           write_cmd,
    input  wire logic                           queue_read,
    // sample engine
    input  wire logic                           sample_valid,
    input  wire logic [acst_pkg::SAMPLE_W-1:0]  x_sample,
    input  wire logic [acst_pkg::SAMPLE_W-1:0]  y_sample,
    input  wire logic [acst_pkg::SAMPLE_W-1:0]  z_sample,
    // detectors and queue
    input  wire logic                           config_upset,
    input  wire logic                           linked_mode,
    input  wire logic                           awake_state,
    input  wire logic                           stillness_detected,
    input  wire logic                           motion_detected,
    input  wire logic                           queue_overrun,
    input  wire logic [acst_pkg::COUNT_W-1:0]   queue_count,
    input  wire logic [acst_pkg::COUNT_W-1:0]   watermark_level,
    // flag view
    output logic      [7:0]                     condition_flags
);
    import acst_pkg::*;

    logic [SAMPLE_W-1:0] x_held;
    logic [SAMPLE_W-1:0] y_held;
    logic [SAMPLE_W-1:0] z_held;
    logic [COUNT_W-1:0]  count_held;
    logic [7:0]          next_rd_data;

    ////////////////////////////////////////////////////////////////////////
    // sample capture, all axes from one sample
    always_ff @(posedge ref_clk) begin
        if (!resetn || soft_reset) begin
            x_held <= RST_SAMPLE;
            y_held <= RST_SAMPLE;
            z_held <= RST_SAMPLE;
        end else if (sample_valid) begin
            x_held <= x_sample; // [R19]
            y_held <= y_sample; // [R19]
            z_held <= z_sample; // [R19]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || soft_reset) begin
            count_held <= '0;
        end else begin
            count_held <= queue_count; // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // condition flags
    always_ff @(posedge ref_clk) begin
        if (!resetn || soft_reset) begin
            condition_flags <= RST_CONDITION_FLAGS; // [R5]
            condition_flags[FLG_CONFIG_ERROR] <= 1'b1; // [R6]
        end else begin
            // set wins over clear
            if (config_upset) begin
                condition_flags[FLG_CONFIG_ERROR] <= 1'b1; // [R7]
            end else if (write_cmd) begin
                condition_flags[FLG_CONFIG_ERROR] <= 1'b0; // [R6]
            end
            condition_flags[FLG_AWAKE]     <= linked_mode ? awake_state : 1'b1; // [R8]
            condition_flags[FLG_STILLNESS] <= stillness_detected; // [R9]
            condition_flags[FLG_MOTION]    <= motion_detected; // [R10]
            condition_flags[FLG_OVERRUN]   <= queue_overrun; // [R11]
            condition_flags[FLG_WATERMARK] <= (queue_count >= watermark_level); // [R12]
            condition_flags[FLG_QUEUE_READY] <= (queue_count != '0); // [R13]
            if (sample_valid) begin
                condition_flags[FLG_DATA_READY] <= 1'b1; // [R14]
            end else if (queue_read) begin
                condition_flags[FLG_DATA_READY] <= 1'b0; // [R14]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read decode; write_cmd to registers up to 0x2C assumed in standby [R1]
    always_comb begin
        case (rd_addr)
            OFS_VENDOR_CODE:        next_rd_data = VENDOR_CODE; // [R2]
            OFS_FAMILY_CODE:        next_rd_data = FAMILY_CODE; // [R2]
            OFS_PART_CODE:          next_rd_data = PART_CODE; // [R2]
            OFS_SILICON_REVISION:   next_rd_data = SILICON_REV; // [R3]
            OFS_X_ACCEL_UPPER_BYTE: next_rd_data = x_held[11:4]; // [R4]
            OFS_Y_ACCEL_UPPER_BYTE: next_rd_data = y_held[11:4]; // [R4]
            OFS_Z_ACCEL_UPPER_BYTE: next_rd_data = z_held[11:4]; // [R4]
            OFS_CONDITION_FLAGS:    next_rd_data = condition_flags; // [R5]
            OFS_QUEUE_COUNT_LOW:    next_rd_data = count_held[7:0]; // [R16]
            OFS_QUEUE_COUNT_HIGH:   next_rd_data = {6'h00, count_held[9:8]}; // [R16]
            OFS_X_ACCEL_LOW_BYTE:   next_rd_data = x_held[7:0]; // [R17]
            OFS_X_ACCEL_HIGH_BYTE:  next_rd_data = {{4{x_held[11]}}, x_held[11:8]}; // [R18]
            default:                next_rd_data = RST_DATA_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rd_data  <= RST_DATA_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_data  <= rd_en ? next_rd_data : rd_data;
            rd_valid <= rd_en;
        end
    end

endmodule : acst_regs

/* File: dv/acst_host.sv */
module acst_host (
    // register read port
    input  wire logic       ref_clk,
    input  wire logic [7:0] rd_data,
    output logic            rd_en,
    output logic      [7:0] rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rd_en = 1'b0;
    initial rd_addr = 8'hFF;
    // read only, never writes
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        rd_addr <= ~a;
        @(posedge ref_clk);
        d = rd_data;
    endtask : rd
endmodule : acst_host

/* File: dv/acst_props.sv */
module acst_props (
    input wire logic       ref_clk, resetn, soft_reset, rd_en, write_cmd, queue_read,
    input wire logic       rd_valid,
    input wire logic       sample_valid, config_upset, linked_mode, stillness_detected,
    input wire logic       motion_detected, queue_overrun,
    input wire logic [7:0] rd_addr, rd_data, condition_flags,
    input wire logic [9:0] queue_count, watermark_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_flag_read: assert property (rd_en && rd_addr == 8'h0B
        |=> rd_data == $past(condition_flags)) else $error("flag read");
    a_write_clears: assert property (write_cmd && !config_upset && !soft_reset
        |=> !condition_flags[7]) else $error("bit 7 kept");
    a_upset_sets: assert property (config_upset |=> condition_flags[7])
        else $error("bit 7 low");
    a_awake_default: assert property (!linked_mode |=> condition_flags[6])
        else $error("bit 6 low");
    a_detect_copy: assert property (!soft_reset |=> condition_flags[5:3] ==
        {$past(stillness_detected), $past(motion_detected), $past(queue_overrun)})
        else $error("bits 5:3");
    a_queue_bits: assert property (!soft_reset |=> condition_flags[2:1] ==
        {$past(queue_count) >= $past(watermark_level), $past(queue_count) != 10'h000})
        else $error("bits 2:1");
    a_new_sample: assert property (sample_valid && !soft_reset |=> condition_flags[0])
        else $error("bit 0 low");
    a_queue_read: assert property (queue_read && !sample_valid && !soft_reset
        |=> !condition_flags[0]) else $error("bit 0 kept");
    a_read_valid: assert property (rd_valid == $past(rd_en) || !$past(resetn))
        else $error("read valid");
    c_upset: cover property (config_upset && write_cmd);
    c_x_high: cover property (rd_en && rd_addr == 8'h0F);
    c_full: cover property (queue_count == 10'h200);
endmodule : acst_props
bind acst_regs acst_props i_props (.*);

/* File: dv/accel_id_status_data_registers_test.sv */
module accel_id_status_data_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = '0, resetn = '0, soft_reset = '0, write_cmd = '0, queue_read = '0;
    logic sample_valid = '0, config_upset = '0, linked_mode = '0, awake_state = '0;
    logic stillness_detected = '0, motion_detected = '0, queue_overrun = '0;
    logic [11:0] x_sample = '0, y_sample = '0, z_sample = '0;
    // watermark above an empty queue, so bit 2 stays low until the count reaches it
    logic [9:0] queue_count = '0, watermark_level = 10'h200;
    logic [7:0] rd_addr, rd_data, condition_flags, d;
    logic rd_en, rd_valid;
    int err_total = 0, n_compared = 0, cyc = 0;
    acst_regs i_dut (.*);
    acst_host i_host (.*);
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic rc(logic [7:0] a, e);
        i_host.rd(a, d);
        n_compared++;
        if (d !== e) begin
            err_total++;
            $display("MISMATCH reg %h exp %h seen %h", a, e, d);
        end
    endtask : rc
    // one edge, then drop all pulses
    task automatic tick;
        @(posedge ref_clk);
        {write_cmd, queue_read, sample_valid, config_upset, soft_reset} <= '0;
    endtask : tick
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rc(8'h0B, 8'hC0);
        rc(8'h00, 8'h5A);
        rc(8'h01, 8'h3C);
        rc(8'h02, 8'h66);
        rc(8'h03, 8'h07);
        write_cmd <= 1'b1;
        tick();
        for (int a = 8; a < 16; a++)
            rc(a[7:0], a == 11 ? 8'h40 : 8'h00);
        {x_sample, y_sample, z_sample} <= {12'h9A5, 12'h37C, 12'h801};
        sample_valid <= 1'b1;
        tick();
        rc(8'h08, 8'h9A);
        rc(8'h09, 8'h37);
        rc(8'h0A, 8'h80);
        rc(8'h0E, 8'hA5);
        rc(8'h0F, 8'hF9);
        rc(8'h0B, 8'h41);
        queue_read <= 1'b1;
        tick();
        rc(8'h0B, 8'h40);
        x_sample <= 12'h123;
        sample_valid <= 1'b1;
        tick();
        rc(8'h08, 8'h12);
        rc(8'h0F, 8'h01);
        {config_upset, write_cmd} <= 2'h3;
        tick();
        rc(8'h0B, 8'hC1);
        {queue_read, write_cmd} <= 2'h3;
        tick();
        {linked_mode, stillness_detected, motion_detected, queue_overrun} <= 4'hF;
        {queue_count, watermark_level} <= {10'h200, 10'h200};
        tick();
        rc(8'h0B, 8'h3E);
        rc(8'h0C, 8'h00);
        rc(8'h0D, 8'h02);
        {linked_mode, stillness_detected, queue_overrun} <= 3'h0;
        queue_count <= 10'h1FF;
        tick();
        rc(8'h0B, 8'h52);
        rc(8'h0C, 8'hFF);
        rc(8'h0D, 8'h01);
        {motion_detected, queue_count, soft_reset} <= {1'b0, 10'h000, 1'b1};
        tick();
        rc(8'h0B, 8'hC0);
        rc(8'h08, 8'h00);
        complete_run();
    end
endmodule : accel_id_status_data_registers_test
